// ---- hw/sie_defines.svh ----
`ifndef SIE_DEFINES_SVH
`define SIE_DEFINES_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SIE_CLK_HZ 50000000
`define SIE_TICK_MS 1
`define SIE_TEST_PERIOD_MS 8'h0A
`define SIE_TEST_PULSE_US 200
`define SIE_HOLD_TAIL 3'h7

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SIE_OFF_CTRL 12'h000
`define SIE_OFF_FILTER 12'h004
`define SIE_OFF_SIMULT 12'h008
`define SIE_OFF_STATUS 12'h00C

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define SIE_CTRL_EN 0
`define SIE_CTRL_DEV_LO 1
`define SIE_CTRL_ARR_LO 3
`define SIE_CTRL_RST_EN 5
`define SIE_CTRL_RST_MON 6
`define SIE_CTRL_TEST_EN 7
`define SIE_CTRL_START_EN 8
`define SIE_CTRL_SIM_EN 9
`define SIE_CTRL_ERR_EN 10
`define SIE_CTRL_POS_LO 11
`define SIE_CTRL_W 13

// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define SIE_STAT_FAULT_LO 5
`define SIE_STAT_FAULT_HI 7

// ---------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------
`define SIE_CTRL_RST 13'h0000
`define SIE_FILTER_RST 8'h03
`define SIE_SIMULT_RST 16'h0064
`define SIE_FILTER_MIN 8'h03
`define SIE_FILTER_MAX 8'hFA

`endif

// ---- hw/sie_pkg.sv ----
package sie_pkg;

    typedef enum logic [1:0] {
        DEV_KEY = 2'b00,
        DEV_CURTAIN = 2'b01,
        DEV_PEDAL = 2'b10,
        DEV_SELECTOR = 2'b11
    } dev_type_t;

    typedef enum logic [2:0] {
        ST_START_OFF = 3'b000,
        ST_START_ON = 3'b001,
        ST_IDLE = 3'b010,
        ST_ARMED = 3'b011,
        ST_RUN = 3'b100,
        ST_FAULT = 3'b101
    } eval_state_t;

endpackage

// ---- hw/input_filter.sv ----
`timescale 1ns/10ps
module input_filter (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic hold,
    input wire logic din,
    input wire logic [7:0] filter_ms,
    output logic level_r
);
    logic [7:0] cnt_r;

    // a change is taken only after filter_ms whole ticks of stability
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level_r <= 1'b0;
            cnt_r <= 8'h00;
        end
        else if (hold)
        begin
            cnt_r <= cnt_r;
        end
        else if (din == level_r)
        begin
            cnt_r <= 8'h00;
        end
        else if (tick)
        begin
            if (cnt_r >= filter_ms)
            begin
                level_r <= din;
                cnt_r <= 8'h00;
            end
            else
            begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
endmodule

// ---- hw/reset_qualifier.sv ----
`timescale 1ns/10ps
module reset_qualifier (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic arm,
    input wire logic monitored,
    input wire logic level,
    output logic accept_r
);
    logic prev_r;
    logic high_seen_r;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            prev_r <= 1'b0;
        else
            prev_r <= level;
    end

    // edges seen before arming never count
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            high_seen_r <= 1'b0;
        else if (!arm)
            high_seen_r <= 1'b0;
        else if (level && !prev_r)
            high_seen_r <= 1'b1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            accept_r <= 1'b0;
        else if (!monitored)
            accept_r <= arm && level && !prev_r;
        else
            accept_r <= arm && high_seen_r && !level && prev_r;
    end
endmodule

// ---- hw/safety_input_evaluator.sv ----
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "sie_defines.svh"
module safety_input_evaluator #(
    parameter int TICK_CYCLES = `SIE_CLK_HZ / 1000 * `SIE_TICK_MS,
    parameter int PULSE_CYCLES = `SIE_CLK_HZ / 1000000 * `SIE_TEST_PULSE_US
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] in_pin,
    input wire logic reset_pin,
    output logic [1:0] test_out,
    output logic out_safe,
    output logic [3:0] sel_out,
    output logic error_out
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int PW = $clog2(PULSE_CYCLES + 1);

    // ---------------------------------------------------------------
    // reset and pin synchronisers
    // ---------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n;
    logic [4:0] pin_meta_r;
    logic [4:0] pin_r;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_r <= 5'h00;
            pin_r <= 5'h00;
        end
        else
        begin
            pin_meta_r <= {reset_pin, in_pin};
            pin_r <= pin_meta_r;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [`SIE_CTRL_W-1:0] ctrl_r;
    logic [7:0] filter_r;
    logic [15:0] simult_r;
    logic [2:0] fault_r;
    logic [2:0] fault_set;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] status;
    logic setup;
    logic access;
    logic addr_ok;
    logic wr;

    assign setup = psel && !penable;
    assign access = psel && penable && pready_r;
    assign addr_ok = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'b00);
    assign wr = access && pwrite && addr_ok;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pready_r <= 1'b0;
        else if (setup)
            pready_r <= 1'b1;
        else if (access)
            pready_r <= 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (setup)
        begin
            pslverr_r <= !addr_ok;
            unique case (paddr)
                `SIE_OFF_CTRL: prdata_r <= {19'h00000, ctrl_r};
                `SIE_OFF_FILTER: prdata_r <= {24'h000000, filter_r};
                `SIE_OFF_SIMULT: prdata_r <= {16'h0000, simult_r};
                `SIE_OFF_STATUS: prdata_r <= status;
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
        else if (access)
            pslverr_r <= 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= `SIE_CTRL_RST;
            filter_r <= `SIE_FILTER_RST;
            simult_r <= `SIE_SIMULT_RST;
        end
        else if (wr)
        begin
            if (paddr == `SIE_OFF_CTRL)
                ctrl_r <= pwdata[`SIE_CTRL_W-1:0];
            if (paddr == `SIE_OFF_FILTER)
                filter_r <= pwdata[7:0];
            if (paddr == `SIE_OFF_SIMULT)
                simult_r <= pwdata[15:0];
        end
    end

    // sticky faults, write one to clear; a new fault wins over the clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            fault_r <= 3'h0;
        else if (wr && paddr == `SIE_OFF_STATUS)
            fault_r <= (fault_r & ~pwdata[`SIE_STAT_FAULT_HI:`SIE_STAT_FAULT_LO]) | fault_set;
        else
            fault_r <= fault_r | fault_set;
    end

    // ---------------------------------------------------------------
    // configuration decode
    // ---------------------------------------------------------------
    sie_pkg::dev_type_t dev;
    logic en;
    logic [1:0] arr;
    logic [1:0] pos;
    logic two_ch;
    logic [7:0] filter_ms;
    logic [3:0] pos_mask;

    assign en = ctrl_r[`SIE_CTRL_EN];
    assign dev = sie_pkg::dev_type_t'(ctrl_r[`SIE_CTRL_DEV_LO+:2]);
    assign arr = ctrl_r[`SIE_CTRL_ARR_LO+:2];
    assign pos = ctrl_r[`SIE_CTRL_POS_LO+:2];
    // key: arr 0 one NO, else two NO; pedal: 0 NC, 1 NO, 2 two NC, 3 NO+NC
    assign two_ch = (dev == sie_pkg::DEV_CURTAIN) ||
        (dev == sie_pkg::DEV_KEY && arr != 2'b00) ||
        (dev == sie_pkg::DEV_PEDAL && arr[1]);
    // out-of-range settings are clamped rather than refused
    assign filter_ms = (filter_r < `SIE_FILTER_MIN) ? `SIE_FILTER_MIN :
        (filter_r > `SIE_FILTER_MAX) ? `SIE_FILTER_MAX : filter_r;
    assign pos_mask = (pos == 2'b00) ? 4'h3 : (pos == 2'b01) ? 4'h7 : 4'hF;

    // ---------------------------------------------------------------
    // millisecond tick
    // ---------------------------------------------------------------
    logic [TW-1:0] tick_cnt_r;
    logic tick_r;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else if (tick_cnt_r == TW'(TICK_CYCLES - 1))
        begin
            tick_cnt_r <= '0;
            tick_r <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + TW'(1);
            tick_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // test pulses
    // ---------------------------------------------------------------
    logic tp_en;
    logic [7:0] period_r;
    logic pulse_on_r;
    logic pulse_ch_r;
    logic [PW-1:0] pulse_cnt_r;
    logic pre_r;
    logic [2:0] tail_r;
    logic [1:0] test_out_r;
    logic pulse_end;
    logic [3:0] hold;

    // curtain lines are monitored by the curtain itself
    assign tp_en = en && ctrl_r[`SIE_CTRL_TEST_EN] &&
        (dev == sie_pkg::DEV_KEY || dev == sie_pkg::DEV_PEDAL);
    assign pulse_end = pulse_on_r && pulse_cnt_r == PW'(PULSE_CYCLES - 1);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            period_r <= 8'h00;
        else if (tick_r)
            period_r <= (period_r >= `SIE_TEST_PERIOD_MS - 8'h01) ? 8'h00 : period_r + 8'h01;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pulse_on_r <= 1'b0;
            pulse_ch_r <= 1'b0;
            pulse_cnt_r <= '0;
            pre_r <= 1'b0;
        end
        else if (!pulse_on_r && tp_en && tick_r && period_r == 8'h00)
        begin
            pulse_on_r <= 1'b1;
            pulse_ch_r <= two_ch && !pulse_ch_r;
            pulse_cnt_r <= '0;
            pre_r <= pin_r[two_ch && !pulse_ch_r];
        end
        else if (pulse_end || !tp_en)
            pulse_on_r <= 1'b0;
        else if (pulse_on_r)
            pulse_cnt_r <= pulse_cnt_r + PW'(1);
    end

    // a closed contact that stays high through its own pulse is shorted
    assign fault_set[1] = pulse_end && !pulse_ch_r && pre_r && pin_r[0];
    assign fault_set[2] = pulse_end && pulse_ch_r && pre_r && pin_r[1];

    // filters freeze while a pulse and its sync lag pass by
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tail_r <= 3'h0;
        else if (pulse_on_r)
            tail_r <= `SIE_HOLD_TAIL;
        else if (tail_r != 3'h0)
            tail_r <= tail_r - 3'h1;
    end

    assign hold = {2'b00, pulse_on_r && pulse_ch_r, pulse_on_r && !pulse_ch_r} |
        {4{tail_r != 3'h0}};

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            test_out_r <= 2'b11;
        else
            test_out_r <= ~{pulse_on_r && pulse_ch_r, pulse_on_r && !pulse_ch_r};
    end

    // ---------------------------------------------------------------
    // debounce
    // ---------------------------------------------------------------
    logic [3:0] filt;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_filt
            input_filter u_filt (
                .clock(clock),
                .rst_n(rst_n),
                .tick(tick_r),
                .hold(hold[gi]),
                .din(pin_r[gi]),
                .filter_ms(filter_ms),
                .level_r(filt[gi])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // evaluation
    // ---------------------------------------------------------------
    logic [3:0] sel_m;
    logic sel_one;
    logic act;
    logic skew;

    assign sel_m = filt & pos_mask;
    assign sel_one = (sel_m != 4'h0) && ((sel_m & (sel_m - 4'h1)) == 4'h0);

    always_comb
    begin
        act = 1'b0;
        skew = 1'b0;
        unique case (dev)
            sie_pkg::DEV_KEY:
            begin
                act = two_ch ? (filt[0] && filt[1]) : filt[0];
                skew = filt[0] ^ filt[1];
            end
            sie_pkg::DEV_CURTAIN:
            begin
                act = filt[0] && filt[1];
                skew = filt[0] ^ filt[1];
            end
            sie_pkg::DEV_PEDAL:
            begin
                // arr 3 has the NO contact on the first channel, NC on the second
                unique case (arr)
                    2'b00: act = !filt[0];
                    2'b01: act = filt[0];
                    2'b10: act = !filt[0] && !filt[1];
                    2'b11: act = filt[0] && !filt[1];
                endcase
                skew = arr[0] ? (filt[0] == filt[1]) : (filt[0] ^ filt[1]);
            end
            sie_pkg::DEV_SELECTOR:
            begin
                act = sel_one;
                skew = (sel_m != 4'h0) && !sel_one;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // simultaneity
    // ---------------------------------------------------------------
    logic sim_on;
    logic [15:0] skew_ms_r;

    assign sim_on = en && (dev == sie_pkg::DEV_CURTAIN || dev == sie_pkg::DEV_SELECTOR ||
        (ctrl_r[`SIE_CTRL_SIM_EN] && two_ch));

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            skew_ms_r <= 16'h0000;
        else if (!sim_on || !skew)
            skew_ms_r <= 16'h0000;
        else if (tick_r && skew_ms_r != 16'hFFFF)
            skew_ms_r <= skew_ms_r + 16'h0001;
    end

    assign fault_set[0] = sim_on && skew && (skew_ms_r > simult_r);

    // ---------------------------------------------------------------
    // output state machine
    // ---------------------------------------------------------------
    sie_pkg::eval_state_t state_r;
    logic fault_any;
    logic rst_accept;
    logic out_safe_r;
    logic [3:0] sel_out_r;
    logic error_out_r;
    logic start_done_r;

    assign fault_any = fault_r != 3'h0;

    // the reset pin sits on the channel after the device's own
    reset_qualifier u_rstq (
        .clock(clock),
        .rst_n(rst_n),
        .arm(state_r == sie_pkg::ST_ARMED),
        .monitored(ctrl_r[`SIE_CTRL_RST_MON]),
        .level(pin_r[4]),
        .accept_r(rst_accept)
    );

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= sie_pkg::ST_START_OFF;
        else if (!en)
            state_r <= start_done_r ? sie_pkg::ST_IDLE : sie_pkg::ST_START_OFF;
        else if (fault_any)
            state_r <= sie_pkg::ST_FAULT;
        else
        begin
            unique case (state_r)
                sie_pkg::ST_START_OFF:
                    if (!ctrl_r[`SIE_CTRL_START_EN])
                        state_r <= sie_pkg::ST_IDLE;
                    else if (!act)
                        state_r <= sie_pkg::ST_START_ON;
                sie_pkg::ST_START_ON:
                    if (act)
                        state_r <= sie_pkg::ST_IDLE;
                sie_pkg::ST_IDLE, sie_pkg::ST_FAULT:
                    if (act)
                        state_r <= ctrl_r[`SIE_CTRL_RST_EN] ? sie_pkg::ST_ARMED
                            : sie_pkg::ST_RUN;
                sie_pkg::ST_ARMED:
                    if (!act)
                        state_r <= sie_pkg::ST_IDLE;
                    else if (rst_accept)
                        state_r <= sie_pkg::ST_RUN;
                sie_pkg::ST_RUN:
                    if (!act)
                        state_r <= sie_pkg::ST_IDLE;
                default:
                    state_r <= sie_pkg::ST_FAULT;
            endcase
        end
    end

    // start-up check is done once per power-up only
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            start_done_r <= 1'b0;
        else if (state_r != sie_pkg::ST_START_OFF && state_r != sie_pkg::ST_START_ON)
            start_done_r <= 1'b1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_safe_r <= 1'b0;
            sel_out_r <= 4'h0;
            error_out_r <= 1'b0;
        end
        else
        begin
            out_safe_r <= en && !fault_any && act && state_r == sie_pkg::ST_RUN;
            sel_out_r <= (en && !fault_any && sel_one && dev == sie_pkg::DEV_SELECTOR &&
                state_r == sie_pkg::ST_RUN) ? sel_m : 4'h0;
            error_out_r <= ctrl_r[`SIE_CTRL_ERR_EN] && fault_any;
        end
    end

    assign status = {17'h00000, error_out_r, state_r == sie_pkg::ST_ARMED, start_done_r,
        filt, fault_r, sel_out_r, out_safe_r};

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign test_out = test_out_r;
    assign out_safe = out_safe_r;
    assign sel_out = sel_out_r;
    assign error_out = error_out_r;
endmodule

// ---- verification/sie_checker.sv ----
`timescale 1ns/10ps
module sie_checker #(
    parameter int TICK_CYCLES = 50,
    parameter int PULSE_CYCLES = 20
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] test_out,
    input wire logic out_safe,
    input wire logic [3:0] sel_out,
    input wire logic error_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // --------------------------------
    // bus and outputs
    // --------------------------------
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_bad: assert property (psel && !penable && (paddr[11:4] != 8'h00 ||
        paddr[1:0] != 2'h0) |=> pslverr) else $error("unmapped access not refused");
    a_slverr_good: assert property (psel && !penable && paddr[11:4] == 8'h00 &&
        paddr[1:0] == 2'h0 |=> !pslverr) else $error("mapped access refused");
    a_slverr_with: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_sel_onehot: assert property ($onehot0(sel_out))
        else $error("more than one selector output");
    a_err_safe_low: assert property (error_out [*3] |-> !out_safe)
        else $error("output high during fault");
    a_test_one_low: assert property (test_out != 2'b00)
        else $error("both test lines low");
    a_pulse_len: assert property ($fell(test_out[0]) |-> !test_out[0] [*8])
        else $error("test pulse too short");
endmodule

// ---- verification/contact_model.sv ----
`timescale 1ns/10ps
module contact_model (
    input wire logic [3:0] contact,
    input wire logic [1:0] short_ch,
    input wire logic reset_cmd,
    input wire logic [1:0] test_out,
    output logic [3:0] in_pin,
    output logic reset_pin
);
    // a closed contact carries the test pulse back; a shorted line never drops
    assign in_pin = {contact[3:2], contact[1:0] & (test_out | short_ch)};
    // reset button sits on the channel right after the device channels
    assign reset_pin = reset_cmd;
endmodule

// ---- verification/safety_input_evaluator_tb_top.sv ----
`timescale 1ns/10ps
module safety_input_evaluator_tb_top;
    localparam int TICK = 50;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic rcmd = 1'b0;
    logic ee;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] rq;
    logic [3:0] contact = 4'h0;
    logic [1:0] short_ch = 2'h0;
    logic [31:0] prdata;
    logic pready, pslverr, reset_pin, out_safe, error_out;
    logic [1:0] test_out;
    logic [3:0] in_pin, sel_out;
    logic [1:0] pr [4] = '{2'b10, 2'b01, 2'b00, 2'b01};
    int num_errors = 0;
    int check_count = 0;

    always #10 clock = ~clock;

    safety_input_evaluator #(.TICK_CYCLES(TICK), .PULSE_CYCLES(20)) safety_input_evaluator_i (
        .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_pin(in_pin), .reset_pin(reset_pin), .test_out(test_out),
        .out_safe(out_safe), .sel_out(sel_out), .error_out(error_out));
    contact_model contact_model_i (.contact(contact), .short_ch(short_ch),
        .reset_cmd(rcmd), .test_out(test_out), .in_pin(in_pin), .reset_pin(reset_pin));

    // --------------------------------
    // helpers
    // --------------------------------
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one transfer; waits for pready, takes data at that edge, then idles a cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rq = prdata;
        ee = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic ms(input int n);
        repeat (n * TICK) @(posedge clock);
    endtask

    task automatic pins(input logic [3:0] c, input int n);
        contact <= c;
        ms(n);
    endtask

    task automatic clr;
        pins(4'h0, 6);
        apb(1'b1, 12'h00C, 32'h000000E0);
        // error flop follows the cleared flags one cycle later
        @(posedge clock);
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] dv, input logic [1:0] ar,
        input logic [7:0] fl);
        return {19'h00000, fl, ar, dv, 1'b1};
    endfunction

    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0); chk(rq, 32'h0);
        apb(1'b0, 12'h004, 32'h0); chk(rq, 32'h3);
        apb(1'b0, 12'h008, 32'h0); chk(rq, 32'h64);
        apb(1'b1, 12'h010, 32'h5); chk(ee, 1'b1); chk(rq, 32'h0);
    endtask

    task automatic t_startup;
        // key already turned when enabled: no off-on cycle seen yet
        pins(4'h3, 6);
        apb(1'b1, 12'h000, ctl(2'h0, 2'h1, 8'h08));
        ms(6); chk(out_safe, 1'b0);
        pins(4'h0, 6);
        pins(4'h3, 6); chk(out_safe, 1'b1);
    endtask

    task automatic t_key;
        apb(1'b1, 12'h000, ctl(2'h0, 2'h1, 8'h00));
        pins(4'h0, 6);
        pins(4'h3, 2); chk(out_safe, 1'b0);
        pins(4'h0, 6);
        pins(4'h3, 6); chk(out_safe, 1'b1);
        pins(4'h0, 6); chk(out_safe, 1'b0);
        apb(1'b1, 12'h000, ctl(2'h0, 2'h0, 8'h00));
        pins(4'h1, 6); chk(out_safe, 1'b1);
    endtask

    task automatic t_reset;
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, 12'h000, ctl(2'h0, 2'h1, m ? 8'h03 : 8'h01));
            pins(4'h0, 6);
            pins(4'h3, 6); chk(out_safe, 1'b0);
            rcmd <= 1'b1;
            ms(6); chk(out_safe, m ? 1'b0 : 1'b1);
            rcmd <= 1'b0;
            ms(6); chk(out_safe, 1'b1);
        end
    endtask

    task automatic t_simult;
        apb(1'b1, 12'h008, 32'h2);
        apb(1'b1, 12'h000, ctl(2'h0, 2'h1, 8'h30));
        pins(4'h1, 10); chk({error_out, out_safe}, 2'b10);
        apb(1'b0, 12'h00C, 32'h0); chk(rq[7:5], 3'h1);
        clr; chk(error_out, 1'b0);
    endtask

    task automatic t_curtain;
        int n;
        n = 0;
        apb(1'b1, 12'h000, ctl(2'h1, 2'h0, 8'h24));
        pins(4'h3, 6); chk(out_safe, 1'b1);
        repeat (15 * TICK)
        begin
            @(posedge clock);
            if (test_out !== 2'b11)
                n++;
        end
        chk(n, 0);
        pins(4'h1, 10); chk(error_out, 1'b1);
        clr;
        pins(4'h3, 6); chk(out_safe, 1'b1);
        pins(4'h0, 6); chk(out_safe, 1'b0);
    endtask

    task automatic t_pedal;
        for (int a = 0; a < 4; a++)
        begin
            apb(1'b1, 12'h000, ctl(2'h2, a[1:0], 8'h00));
            pins({2'b00, ~pr[a]}, 6); chk(out_safe, 1'b0);
            pins({2'b00, pr[a]}, 6); chk(out_safe, 1'b1);
        end
    endtask

    task automatic t_selector;
        apb(1'b1, 12'h008, 32'h64);
        apb(1'b1, 12'h000, ctl(2'h3, 2'h0, 8'h80));
        for (int i = 0; i < 4; i++)
        begin
            pins(4'h1 << i, 6); chk(sel_out, 4'h1 << i);
        end
        pins(4'h5, 6); chk(sel_out, 4'h0);
        apb(1'b1, 12'h000, ctl(2'h3, 2'h0, 8'h00));
        pins(4'h4, 6); chk(sel_out, 4'h0);
        pins(4'h2, 6); chk(sel_out, 4'h2);
    endtask

    task automatic t_short;
        apb(1'b1, 12'h000, ctl(2'h0, 2'h0, 8'h24));
        pins(4'h1, 25); chk({error_out, out_safe}, 2'b01);
        short_ch <= 2'h1;
        ms(25); chk({error_out, out_safe}, 2'b10);
        short_ch <= 2'h0;
        clr;
    endtask

    initial
    begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        t_regs;
        t_startup;
        t_key;
        t_reset;
        t_simult;
        t_curtain;
        t_pedal;
        t_selector;
        t_short;
        print_verdict;
    end

    initial
    begin
        repeat (60000) @(posedge clock);
        num_errors++;
        $display("mismatch at %0t: watchdog timeout", $time);
        print_verdict;
    end
endmodule

bind safety_input_evaluator sie_checker #(.TICK_CYCLES(TICK_CYCLES),
    .PULSE_CYCLES(PULSE_CYCLES)) sie_checker_i (.clock(clock), .resetn(resetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .test_out(test_out), .out_safe(out_safe), .sel_out(sel_out), .error_out(error_out));
